// ===== verilog/ppp_regs.vh
// parallel programming port constants
// assumes inclusion by the port's design files and the testbench
`ifndef PPP_REGS_VH
`define PPP_REGS_VH
// ----------------------------------------------------------------
// action select codes
// ----------------------------------------------------------------
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3
// ----------------------------------------------------------------
// command bytes
// ----------------------------------------------------------------
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WFUSE 8'h40
`define PPP_CMD_WLOCK 8'h20
`define PPP_CMD_WFLASH 8'h10
`define PPP_CMD_WEE 8'h11
`define PPP_CMD_RFUSE 8'h04
`define PPP_CMD_RFLASH 8'h02
`define PPP_CMD_REE 8'h03
`define PPP_CMD_NOP 8'h00
// ----------------------------------------------------------------
// geometry, reset values
// ----------------------------------------------------------------
`define PPP_FLASH_WORDS_LOG2 6
`define PPP_EE_BYTES_LOG2 2
`define PPP_ERASED_BYTE 8'hFF
`define PPP_FUSE_LO_RST 8'h62
`define PPP_FUSE_HI_RST 8'h99
`define PPP_FUSE_EX_RST 8'hFF
`define PPP_LOCK_RST 8'hFF
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PPP_CLK_MHZ 200
`define PPP_WRITE_US 3700
`define PPP_ERASE_US 7500
`define PPP_WRITE_CYC (`PPP_WRITE_US * `PPP_CLK_MHZ)
`define PPP_ERASE_CYC (`PPP_ERASE_US * `PPP_CLK_MHZ)
`endif

// ===== verilog/ppp_sync.v
// two-stage synchroniser for a bundle of pin levels
// assumes the pins are asynchronous to clk_sys
`timescale 1ns/1ps
module ppp_sync #(
  parameter W = 1
) (
  input wire clk_sys,
  input wire rstn,
  input wire [W-1:0] pin,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta <= pin;
      q <= meta;
    end
  end
endmodule

// ===== verilog/ppp_port.v
// parallel programming port: command, address and data loading,
// page buffers, flash and eeprom arrays, fuse and lock bytes
// assumes pins come from an external programmer, async to clk_sys
//
// Functional notes
// - command and address stay loaded across operations
// - erase clears flash, eeprom, locks; locks last; fuses kept
// - preserve fuse programmed keeps eeprom through erase
// - command 80 loaded with action 10, select low, load strobe
// - write strobe starts erase, busy low until done
// - flash data gathered in a 64-word page buffer
// - write flash command 10 loaded via action 10
// - action 00 loads low or high address byte by byte select
// - action 01 loads low or high data byte by byte select
// - page load strobe latches data word into buffer at address
// - low address bits pick word, upper bits pick page
// - write strobe programs buffered flash page, busy low
// - command 00 resets internal write signals
// - command 11 programs buffered eeprom page on write strobe with byte select 1 low
// - read flash drives low or high word byte while oe low
// - read eeprom drives addressed byte while oe low
// - fuse data bit 0 programs, 1 erases
// - byte selects choose low, high or extended fuse byte
// - lock bit programmed by 0; boot locks refused in mode 3
// - programmed lock bits cleared only by chip erase
// - action 11 on load strobe does nothing
// - ready_busy low while programming, high when ready
// - data bus driven only while oe low
`timescale 1ns/1ps
`include "ppp_regs.vh"
module ppp_port #(
  parameter WORD_LOG2 = `PPP_FLASH_WORDS_LOG2,
  parameter FLASH_AW = 13,
  parameter EE_LOG2 = `PPP_EE_BYTES_LOG2,
  parameter EE_AW = 9,
  parameter WRITE_CYC = `PPP_WRITE_CYC,
  parameter ERASE_CYC = `PPP_ERASE_CYC
) (
  input wire clk_sys,
  input wire rstn,
  input wire load_strobe,
  input wire page_load_strobe,
  input wire write_strobe_n,
  input wire output_enable_n,
  input wire action_select_hi,
  input wire action_select_lo,
  input wire byte_select_1,
  input wire byte_select_2,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output wire data_oe,
  output reg ready_busy,
  output wire [7:0] fuse_lo,
  output wire [7:0] fuse_hi,
  output wire [7:0] fuse_ex,
  output wire [7:0] lock_bits,
  output wire eeprom_preserve_fuse
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [15:0] s;
  ppp_sync #(.W(16)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pin({load_strobe, page_load_strobe, ~write_strobe_n,
      ~output_enable_n, action_select_hi, action_select_lo,
      byte_select_1, byte_select_2, data_in}),
    .q(s)
  );
  wire ls = s[15];
  wire pl = s[14];
  wire wr = s[13];
  wire oe = s[12];
  wire [1:0] act = s[11:10];
  wire bs1 = s[9];
  wire bs2 = s[8];
  wire [7:0] din = s[7:0];
  reg ls_d, pl_d, wr_d;
  wire ls_rise = ls & ~ls_d;
  wire pl_rise = pl & ~pl_d;
  wire wr_fall = wr & ~wr_d;
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  localparam FW = 1 << FLASH_AW;
  localparam EW = 1 << EE_AW;
  localparam PW = 1 << WORD_LOG2;
  localparam EP = 1 << EE_LOG2;
  reg [15:0] flash_mem [0:FW-1];
  reg [7:0] ee_mem [0:EW-1];
  reg [15:0] fbuf [0:PW-1];
  reg [7:0] ebuf [0:EP-1];
  reg [PW-1:0] fbuf_v;
  reg [EP-1:0] ebuf_v;
  reg [7:0] cmd, addr_lo, addr_hi, dlo, dhi;
  reg [7:0] f_lo, f_hi, f_ex, lock;
  assign fuse_lo = f_lo;
  assign fuse_hi = f_hi;
  assign fuse_ex = f_ex;
  assign lock_bits = lock;
  // preserve fuse sits at bit 3 of the high fuse byte, 0 = programmed
  assign eeprom_preserve_fuse = ~f_hi[3];
  wire [15:0] addr = {addr_hi, addr_lo};
  // ----------------------------------------------------------------
  // operation state machine
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_WAIT = 3'h1;
  localparam ST_FLASH = 3'h2;
  localparam ST_EE = 3'h3;
  localparam ST_ERASE_MEM = 3'h4;
  localparam ST_ERASE_LOCK = 3'h5;
  reg [2:0] state;
  reg [2:0] pend;
  reg [31:0] cnt;
  reg [FLASH_AW:0] idx;
  reg [7:0] wbyte;
  reg [1:0] wsel;
  function [FLASH_AW-1:0] page_base;
    input [15:0] a;
    begin
      page_base = {a[FLASH_AW-1:WORD_LOG2], {WORD_LOG2{1'b0}}};
    end
  endfunction
  function [EE_AW-1:0] ee_base;
    input [15:0] a;
    begin
      ee_base = {a[EE_AW-1:EE_LOG2], {EE_LOG2{1'b0}}};
    end
  endfunction
  // ----------------------------------------------------------------
  // derived conditions
  // ----------------------------------------------------------------
  wire [31:0] wait_len = (pend == ST_ERASE_MEM) ? ERASE_CYC : WRITE_CYC;
  wire lock_mode3 = (lock[1:0] == 2'h0);
  wire fl_pl = pl_rise & bs1 & (cmd == `PPP_CMD_WFLASH);
  wire ee_pl = pl_rise & bs1 & (cmd == `PPP_CMD_WEE);
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ls_d <= 1'b0;
      pl_d <= 1'b0;
      wr_d <= 1'b0;
      cmd <= `PPP_CMD_NOP;
      addr_lo <= 8'h00;
      addr_hi <= 8'h00;
      dlo <= 8'h00;
      dhi <= 8'h00;
      f_lo <= `PPP_FUSE_LO_RST;
      f_hi <= `PPP_FUSE_HI_RST;
      f_ex <= `PPP_FUSE_EX_RST;
      lock <= `PPP_LOCK_RST;
      fbuf_v <= {PW{1'b0}};
      ebuf_v <= {EP{1'b0}};
      state <= ST_IDLE;
      pend <= ST_IDLE;
      cnt <= 32'h00000000;
      idx <= {(FLASH_AW+1){1'b0}};
      wbyte <= 8'h00;
      wsel <= 2'h0;
      ready_busy <= 1'b1;
    end else begin
      ls_d <= ls;
      pl_d <= pl;
      wr_d <= wr;
      // load strobe actions, held values persist
      if (ls_rise) begin
        case (act)
          `PPP_ACT_ADDR: begin
            if (bs1) begin
              addr_hi <= din;
            end else begin
              addr_lo <= din;
            end
          end
          `PPP_ACT_DATA: begin
            if (bs1) begin
              dhi <= din;
            end else begin
              dlo <= din;
            end
          end
          `PPP_ACT_CMD: begin
            cmd <= din;
            if (din == `PPP_CMD_NOP) begin
              fbuf_v <= {PW{1'b0}};
              ebuf_v <= {EP{1'b0}};
            end
          end
          default: begin
          end
        endcase
      end
      // page load latches into buffers
      if (fl_pl) begin
        fbuf[addr[WORD_LOG2-1:0]] <= {dhi, dlo};
        fbuf_v[addr[WORD_LOG2-1:0]] <= 1'b1;
      end
      if (ee_pl) begin
        ebuf[addr[EE_LOG2-1:0]] <= dlo;
        ebuf_v[addr[EE_LOG2-1:0]] <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (wr_fall) begin
            cnt <= 32'h00000000;
            idx <= {(FLASH_AW+1){1'b0}};
            case (cmd)
              `PPP_CMD_ERASE: begin
                pend <= ST_ERASE_MEM;
                state <= ST_WAIT;
                ready_busy <= 1'b0;
              end
              `PPP_CMD_WFLASH: begin
                pend <= ST_FLASH;
                state <= ST_WAIT;
                ready_busy <= 1'b0;
              end
              `PPP_CMD_WEE: begin
                if (!bs1) begin
                  pend <= ST_EE;
                  state <= ST_WAIT;
                  ready_busy <= 1'b0;
                end
              end
              `PPP_CMD_WFUSE: begin
                wbyte <= dlo;
                wsel <= bs2 ? 2'h2 : (bs1 ? 2'h1 : 2'h0);
                pend <= ST_IDLE;
                state <= ST_WAIT;
                ready_busy <= 1'b0;
              end
              `PPP_CMD_WLOCK: begin
                wbyte <= dlo;
                wsel <= 2'h3;
                pend <= ST_IDLE;
                state <= ST_WAIT;
                ready_busy <= 1'b0;
              end
              default: begin
              end
            endcase
          end
        end
        ST_WAIT: begin
          // self-timed write delay, then the memory action
          cnt <= cnt + 32'h00000001;
          if (cnt >= wait_len - 32'h00000001) begin
            state <= pend;
            if (pend == ST_IDLE) begin
              ready_busy <= 1'b1;
              case (wsel)
                2'h0: f_lo <= wbyte;
                2'h1: f_hi <= wbyte;
                2'h2: f_ex <= wbyte;
                default: begin
                  // only clearing toward programmed
                  lock[1:0] <= lock[1:0] & wbyte[1:0];
                  if (!lock_mode3) begin
                    lock[7:2] <= lock[7:2] & wbyte[7:2];
                  end
                end
              endcase
            end
          end
        end
        ST_FLASH: begin
          if (fbuf_v[idx[WORD_LOG2-1:0]]) begin
            flash_mem[page_base(addr) | idx[FLASH_AW-1:0]] <=
              fbuf[idx[WORD_LOG2-1:0]];
          end
          idx <= idx + 1'b1;
          if (idx[WORD_LOG2-1:0] == PW - 1) begin
            fbuf_v <= {PW{1'b0}};
            state <= ST_IDLE;
            ready_busy <= 1'b1;
          end
        end
        ST_EE: begin
          if (ebuf_v[idx[EE_LOG2-1:0]]) begin
            ee_mem[ee_base(addr) | idx[EE_AW-1:0]] <=
              ebuf[idx[EE_LOG2-1:0]];
          end
          idx <= idx + 1'b1;
          if (idx[EE_LOG2-1:0] == EP - 1) begin
            ebuf_v <= {EP{1'b0}};
            state <= ST_IDLE;
            ready_busy <= 1'b1;
          end
        end
        ST_ERASE_MEM: begin
          flash_mem[idx[FLASH_AW-1:0]] <=
            {`PPP_ERASED_BYTE, `PPP_ERASED_BYTE};
          if (!eeprom_preserve_fuse && idx < EW) begin
            ee_mem[idx[EE_AW-1:0]] <= `PPP_ERASED_BYTE;
          end
          idx <= idx + 1'b1;
          if (idx == FW - 1) begin
            state <= ST_ERASE_LOCK;
          end
        end
        ST_ERASE_LOCK: begin
          lock <= `PPP_LOCK_RST;
          state <= ST_IDLE;
          ready_busy <= 1'b1;
        end
        default: begin
          state <= ST_IDLE;
          ready_busy <= 1'b1;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire [15:0] fword = flash_mem[addr[FLASH_AW-1:0]];
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      data_out <= 8'h00;
    end else begin
      case (cmd)
        `PPP_CMD_RFLASH: begin
          data_out <= bs1 ? fword[15:8] : fword[7:0];
        end
        `PPP_CMD_REE: data_out <= ee_mem[addr[EE_AW-1:0]];
        `PPP_CMD_RFUSE: begin
          case ({bs2, bs1})
            2'b00: data_out <= f_lo;
            2'b11: data_out <= f_hi;
            2'b10: data_out <= f_ex;
            default: data_out <= lock;
          endcase
        end
        default: data_out <= 8'h00;
      endcase
    end
  end
  assign data_oe = oe;
endmodule

// ===== dv/ppp_chk.sv
// checker on the programming port pins
// assumes binding onto ppp_port, single clock domain
`timescale 1ns/1ps
module ppp_chk #(
  parameter BUSY_MAX = 9000
) (
  input wire clk_sys,
  input wire rstn,
  input wire write_strobe_n,
  input wire output_enable_n,
  input wire data_oe,
  input wire ready_busy,
  input wire [7:0] fuse_hi,
  input wire [7:0] lock_bits,
  input wire eeprom_preserve_fuse
);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  sequence s_wr_seen;
    !$past(write_strobe_n) || !$past(write_strobe_n, 2) ||
    !$past(write_strobe_n, 3) || !$past(write_strobe_n, 4);
  endsequence
  sequence s_busy_hold;
    !ready_busy [*7];
  endsequence
  // busy length counter
  reg [31:0] busy_cyc;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_cyc <= 32'h00000000;
    end else if (ready_busy) begin
      busy_cyc <= 32'h00000000;
    end else begin
      busy_cyc <= busy_cyc + 32'h00000001;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_oe_off_idle: assert property (output_enable_n [*4] |-> !data_oe)
    else $error("bus driven with output enable high");
  a_oe_has_cause: assert property (data_oe |->
    !output_enable_n || !$past(output_enable_n) ||
    !$past(output_enable_n, 2) || !$past(output_enable_n, 3))
    else $error("bus driven without output enable");
  a_busy_from_wr: assert property (
    $fell(ready_busy) |-> s_wr_seen)
    else $error("busy without write strobe");
  a_busy_min_len: assert property (
    $fell(ready_busy) |=> s_busy_hold)
    else $error("busy too short");
  a_busy_ends: assert property (busy_cyc < BUSY_MAX)
    else $error("busy never ends");
  a_lock_sticky: assert property (
    |(lock_bits & ~$past(lock_bits)) |->
    !ready_busy || !$past(ready_busy))
    else $error("lock bit cleared outside erase");
  a_boot_refused: assert property ($past(lock_bits[1:0]) == 2'h0 |->
    (~lock_bits[7:2] & $past(lock_bits[7:2])) == 6'h00)
    else $error("boot lock programmed in mode 3");
  a_preserve_map: assert property (
    eeprom_preserve_fuse == !fuse_hi[3])
    else $error("preserve flag not from fuse");
endmodule
bind ppp_port ppp_chk #(
  .BUSY_MAX(ERASE_CYC + (1 << FLASH_AW) + 8)
) ppp_chk_inst (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .write_strobe_n(write_strobe_n),
  .output_enable_n(output_enable_n),
  .data_oe(data_oe),
  .ready_busy(ready_busy),
  .fuse_hi(fuse_hi),
  .lock_bits(lock_bits),
  .eeprom_preserve_fuse(eeprom_preserve_fuse)
);

// ===== dv/ppp_prog_model.sv
// external parallel programmer driving the port pins
// assumes the bench resolves the data bus and calls the tasks
`timescale 1ns/1ps
module ppp_prog_model (
  input wire clk_sys,
  input wire ready_busy,
  input wire [7:0] bus,
  output reg load_strobe = 1'b0,
  output reg page_load_strobe = 1'b0,
  output reg write_strobe_n = 1'b1,
  output reg output_enable_n = 1'b1,
  output reg action_select_hi = 1'b1,
  output reg action_select_lo = 1'b1,
  output reg byte_select_1 = 1'b0,
  output reg byte_select_2 = 1'b0,
  output reg [7:0] drv = 8'h00
);
  integer gap = 4;
  reg timed_out = 1'b0;
  // ----------------------------------------------------------------
  // pin sequences
  // ----------------------------------------------------------------
  task idle(input integer n);
    repeat (n) @(negedge clk_sys);
  endtask
  // selects and byte set up, then load strobe pulse
  task load(input [1:0] act, input bs, input [7:0] d);
    action_select_hi = act[1];
    action_select_lo = act[0];
    byte_select_1 = bs;
    drv = d;
    idle(gap);
    load_strobe = 1'b1;
    idle(gap);
    load_strobe = 1'b0;
    idle(gap);
  endtask
  task latch;
    byte_select_1 = 1'b1;
    idle(gap);
    page_load_strobe = 1'b1;
    idle(gap);
    page_load_strobe = 1'b0;
    idle(gap);
  endtask
  // write pulse, then wait for ready; selects back to low byte
  task wr(input b1, input b2, input wt);
    integer n;
    byte_select_1 = b1;
    byte_select_2 = b2;
    idle(gap);
    write_strobe_n = 1'b0;
    idle(gap);
    write_strobe_n = 1'b1;
    for (n = 0; wt && n < 10000 && ready_busy !== 1'b1; n = n + 1) begin
      @(negedge clk_sys);
    end
    if (n == 10000) begin
      timed_out = 1'b1;
    end
    byte_select_1 = 1'b0;
    byte_select_2 = 1'b0;
    idle(gap);
  endtask
  task rd(input b1, output [7:0] v);
    byte_select_1 = b1;
    output_enable_n = 1'b0;
    idle(6);
    v = bus;
    output_enable_n = 1'b1;
    idle(gap);
  endtask
endmodule

// ===== dv/testbench.sv
// self-checking bench for the programming port
// assumes ppp_regs.vh on the include path
`timescale 1ns/1ps
`include "ppp_regs.vh"
module testbench;
  reg clk_sys;
  reg rstn = 1'b0;
  integer err_count = 0;
  integer n_checks = 0;
  integer cyc = 0;
  wire [7:0] data_out, drv, fuse_lo, fuse_hi, fuse_ex, lock_bits;
  wire data_oe, ready_busy, eeprom_preserve_fuse;
  wire ls, pls, wr_n, oe_n, ah, al, b1, b2;
  wire [7:0] bus = data_oe ? data_out : (oe_n ? drv : ~drv);
  ppp_port #(.WRITE_CYC(20), .ERASE_CYC(20)) ppp_port_inst (
    .clk_sys(clk_sys), .rstn(rstn), .load_strobe(ls),
    .page_load_strobe(pls), .write_strobe_n(wr_n),
    .output_enable_n(oe_n), .action_select_hi(ah),
    .action_select_lo(al), .byte_select_1(b1), .byte_select_2(b2),
    .data_in(bus), .data_out(data_out), .data_oe(data_oe),
    .ready_busy(ready_busy), .fuse_lo(fuse_lo), .fuse_hi(fuse_hi),
    .fuse_ex(fuse_ex), .lock_bits(lock_bits),
    .eeprom_preserve_fuse(eeprom_preserve_fuse));
  ppp_prog_model pg (
    .clk_sys(clk_sys), .ready_busy(ready_busy), .bus(bus),
    .load_strobe(ls), .page_load_strobe(pls), .write_strobe_n(wr_n),
    .output_enable_n(oe_n), .action_select_hi(ah),
    .action_select_lo(al), .byte_select_1(b1), .byte_select_2(b2),
    .drv(drv));
  // ----------------------------------------------------------------
  // clock, timeout, helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count = err_count + 1;
      complete_run;
    end
  end
  task complete_run;
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count = err_count + 1;
    end
  endtask
  task rdw(input [7:0] a, input [15:0] e);
    reg [7:0] v;
    pg.load(2'h0, 1'b0, a);
    pg.rd(1'b0, v);
    chk(v, e[7:0]);
    pg.rd(1'b1, v);
    chk(v, e[15:8]);
  endtask
  task rde(input [7:0] a, input [7:0] e);
    reg [7:0] v;
    pg.load(2'h0, 1'b0, a);
    pg.rd(1'b0, v);
    chk(v, e);
  endtask
  task cmd(input [7:0] c);
    pg.load(2'h2, 1'b0, c);
  endtask
  task wfuse(input [7:0] d, input s1, input s2);
    pg.load(2'h1, 1'b0, d);
    pg.load(2'h3, 1'b0, 8'h00);
    pg.wr(s1, s2, 1'b1);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_flash;
    cmd(`PPP_CMD_ERASE);
    pg.wr(1'b0, 1'b0, 1'b1);
    cmd(`PPP_CMD_WFLASH);
    pg.load(2'h0, 1'b0, 8'h3F);
    pg.load(2'h1, 1'b0, 8'h5A);
    pg.load(2'h1, 1'b1, 8'hA5);
    pg.latch;
    pg.load(2'h0, 1'b0, 8'h41);
    pg.load(2'h1, 1'b0, 8'h34);
    pg.load(2'h1, 1'b1, 8'h12);
    pg.latch;
    pg.load(2'h0, 1'b1, 8'h00);
    pg.wr(1'b0, 1'b0, 1'b1);
    cmd(`PPP_CMD_NOP);
    cmd(`PPP_CMD_RFLASH);
    pg.load(2'h0, 1'b1, 8'h00);
    rdw(8'h7F, 16'hA55A);
    rdw(8'h41, 16'h1234);
    rdw(8'h3F, 16'hFFFF);
  endtask
  task t_eeprom;
    cmd(`PPP_CMD_WEE);
    pg.load(2'h0, 1'b1, 8'h00);
    pg.load(2'h0, 1'b0, 8'h05);
    pg.load(2'h1, 1'b0, 8'h3C);
    pg.latch;
    pg.load(2'h0, 1'b0, 8'h06);
    pg.load(2'h1, 1'b0, 8'hC3);
    pg.latch;
    pg.wr(1'b0, 1'b0, 1'b1);
    pg.wr(1'b1, 1'b0, 1'b0);
    chk({7'h00, ready_busy}, 8'h01);
    cmd(`PPP_CMD_REE);
    rde(8'h05, 8'h3C);
    rde(8'h06, 8'hC3);
    rde(8'h04, 8'hFF);
  endtask
  task t_fuse;
    reg [7:0] v;
    cmd(`PPP_CMD_WFUSE);
    wfuse(8'hE1, 1'b0, 1'b0);
    chk(fuse_lo, 8'hE1);
    wfuse(8'h91, 1'b1, 1'b0);
    chk(fuse_hi, 8'h91);
    chk({7'h00, eeprom_preserve_fuse}, 8'h01);
    wfuse(8'hF0, 1'b0, 1'b1);
    chk(fuse_ex, 8'hF0);
    pg.load(2'h1, 1'b0, 8'h77);
    pg.wr(1'b0, 1'b0, 1'b0);
    pg.wr(1'b0, 1'b1, 1'b1);
    chk(fuse_lo, 8'h77);
    chk(fuse_ex, 8'hF0);
    cmd(`PPP_CMD_RFUSE);
    pg.rd(1'b0, v);
    chk(v, 8'h77);
    pg.rd(1'b1, v);
    chk(v, `PPP_LOCK_RST);
  endtask
  task t_erase(input [7:0] ee);
    cmd(`PPP_CMD_ERASE);
    pg.wr(1'b0, 1'b0, 1'b1);
    chk(fuse_lo, 8'h77);
    cmd(`PPP_CMD_RFLASH);
    pg.load(2'h0, 1'b1, 8'h00);
    rdw(8'h7F, 16'hFFFF);
    cmd(`PPP_CMD_REE);
    rde(8'h05, ee);
  endtask
  task t_lock;
    pg.gap = 9;
    cmd(`PPP_CMD_WLOCK);
    wfuse(8'hFC, 1'b0, 1'b0);
    chk(lock_bits, 8'hFC);
    wfuse(8'h00, 1'b0, 1'b0);
    chk(lock_bits, 8'hFC);
    wfuse(8'hFF, 1'b0, 1'b0);
    chk(lock_bits, 8'hFC);
    pg.gap = 4;
    cmd(`PPP_CMD_WFUSE);
    wfuse(8'h99, 1'b1, 1'b0);
    t_erase(8'hFF);
    chk(lock_bits, 8'hFF);
    chk(fuse_hi, 8'h99);
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    pg.idle(4);
    chk(fuse_lo, `PPP_FUSE_LO_RST);
    chk(fuse_hi, `PPP_FUSE_HI_RST);
    chk(lock_bits, `PPP_LOCK_RST);
    chk({6'h00, ready_busy, data_oe}, 8'h02);
    t_flash;
    t_eeprom;
    t_fuse;
    t_erase(8'h3C);
    t_lock;
    chk({7'h00, pg.timed_out}, 8'h00);
    complete_run;
  end
endmodule
